// ==== ctidd_defines.svh ====
// register offsets, field positions and reset values of the descriptor decoder
`ifndef CTIDD_DEFINES_SVH
`define CTIDD_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CTIDD_OFF_CTRL 8'h00
`define CTIDD_OFF_STATUS 8'h04
`define CTIDD_OFF_SCALE 8'h08
`define CTIDD_OFF_WAIT 8'h0C
`define CTIDD_OFF_RDYBSY 8'h10
`define CTIDD_OFF_RSV 8'h14
`define CTIDD_OFF_IOCNT 8'h18
`define CTIDD_OFF_IOLAST 8'h1C
`define CTIDD_OFF_INT_STAT 8'h20
`define CTIDD_OFF_INT_EN 8'h24
`define CTIDD_OFF_INT_CLR 8'h28

// ****************************************
// field positions
// ****************************************
`define CTIDD_CTRL_START 0
`define CTIDD_CTRL_SEL_IO 1
`define CTIDD_WAIT_LO 0
`define CTIDD_WAIT_HI 1
`define CTIDD_RB_LO 2
`define CTIDD_RB_HI 4
`define CTIDD_RSV_LO 5
`define CTIDD_RSV_HI 7
`define CTIDD_EXT_BIT 7
`define CTIDD_INT_DONE 0
`define CTIDD_INT_ERR 1

// ****************************************
// special values and reset values
// ****************************************
`define CTIDD_WAIT_ABSENT 2'h3
`define CTIDD_RB_ABSENT 3'h7
`define CTIDD_RSV_ABSENT 3'h7
`define CTIDD_IO_GROUP_LAST 2'h2
`define CTIDD_RST_WORD 32'h0000_0000
`define CTIDD_RST_BYTE 8'h00

`endif

// ==== ctidd_pkg.sv ====
// types shared by the descriptor decoder files
package ctidd_pkg;

  typedef enum logic [2:0] {
    CTIDD_IDLE = 3'b000,
    CTIDD_SCALE = 3'b001,
    CTIDD_WAIT = 3'b010,
    CTIDD_RB = 3'b011,
    CTIDD_RSV = 3'b100,
    CTIDD_IO = 3'b101
  } ctidd_state_type;

  typedef logic [7:0] ctidd_byte_type;

endpackage : ctidd_pkg

// ==== ctidd_ext_value.sv ====
// collector for one multi-byte speed value: first byte and byte count
`timescale 1ns/10ps
`include "ctidd_defines.svh"

module ctidd_ext_value (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLEAR,
  input wire logic TAKE,
  input wire ctidd_pkg::ctidd_byte_type DATA,
  output logic FINAL,
  output ctidd_pkg::ctidd_byte_type FIRST,
  output logic [7:0] COUNT
);
  import ctidd_pkg::*;

  logic [7:0] count_ff;
  ctidd_byte_type first_ff;

  // last byte of a value is the first one with the extension bit clear
  assign FINAL = ~DATA[`CTIDD_EXT_BIT];
  assign FIRST = (count_ff == 8'h00) ? DATA : first_ff;
  assign COUNT = count_ff + 8'h01;

  always_ff @(posedge CLK) begin
    if (SYS_RST || CLEAR) begin
      count_ff <= `CTIDD_RST_BYTE;
    end else if (TAKE) begin
      // saturate count_ff at 8'hFF; COUNT is count_ff + 8'h01 and so still wraps to 8'h00 there
      count_ff <= (FINAL) ? 8'h00 : ((count_ff == 8'hFF) ? count_ff : count_ff + 8'h01);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      first_ff <= `CTIDD_RST_BYTE;
    end else if (TAKE && count_ff == 8'h00) begin
      first_ff <= DATA;
    end
  end

endmodule : ctidd_ext_value

// ==== ctidd_decoder.sv ====
// timing and i/o-space descriptor decoder with apb register access
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "ctidd_defines.svh"

// Overview of operation
// - the timing field opens with one scale byte, then unscaled speed-code bytes follow.
// - scale bits 1..0 are the power-of-ten multiplier of the maximum wait time.
// - a wait multiplier of 3 means no wait line and no wait speed bytes.
// - scale bits 4..2 are the power-of-ten multiplier of the maximum busy time.
// - a ready/busy multiplier of 7 means no ready/busy line and no busy-time bytes.
// - scale bits 7..5 are the reserved multiplier, and 7 means no reserved bytes follow.
// - present values are parsed wait, then ready/busy, then reserved, absent ones skipped.
// - the i/o-space field is parsed as groups of three bytes, one address range each.
// - groups continue while the group's continuation flag is set, ending after a clear one.
// - a value keeps taking bytes while bit 7 is set; the first with bit 7 clear ends it.

module ctidd_decoder (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SRC_VALID,
  input wire ctidd_pkg::ctidd_byte_type SRC_DATA,
  input wire logic SRC_LAST,
  output logic SRC_READY,
  output logic IRQ
);
  import ctidd_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  ctidd_state_type state_ff;
  ctidd_state_type nxt_state;
  ctidd_byte_type scale_ff;
  logic [15:0] wait_ff;
  logic [15:0] rb_ff;
  logic [15:0] rsv_ff;
  logic [7:0] io_count_ff;
  logic [23:0] io_last_ff;
  logic [1:0] io_idx_ff;
  logic io_cont_ff;
  logic sel_io_ff;
  logic done_ff;
  logic err_ff;
  logic [1:0] int_stat_ff;
  logic [1:0] int_en_ff;
  logic take;
  logic in_value;
  logic val_final;
  ctidd_byte_type val_first;
  logic [7:0] val_count;
  logic finish;
  logic more_due;
  logic early_end;
  logic wr_en;
  logic rd_en;
  logic start;
  logic addr_ok;

  // next present timing field after the given one, idle when none remain
  function automatic ctidd_state_type next_field(input ctidd_state_type from,
                                                 input ctidd_byte_type sc);
    ctidd_state_type res;
    res = CTIDD_IDLE;
    if (from == CTIDD_SCALE && sc[`CTIDD_WAIT_HI:`CTIDD_WAIT_LO] != `CTIDD_WAIT_ABSENT) begin
      res = CTIDD_WAIT;
    end else if ((from == CTIDD_SCALE || from == CTIDD_WAIT) &&
                 sc[`CTIDD_RB_HI:`CTIDD_RB_LO] != `CTIDD_RB_ABSENT) begin
      res = CTIDD_RB;
    end else if (from != CTIDD_RSV && sc[`CTIDD_RSV_HI:`CTIDD_RSV_LO] != `CTIDD_RSV_ABSENT) begin
      res = CTIDD_RSV;
    end
    return res;
  endfunction : next_field

  // ****************************************
  // byte stream handshake
  // ****************************************
  assign SRC_READY = (state_ff != CTIDD_IDLE);
  assign take = SRC_VALID && SRC_READY;
  assign in_value = (state_ff == CTIDD_WAIT) || (state_ff == CTIDD_RB) || (state_ff == CTIDD_RSV);
  assign start = wr_en && PADDR == `CTIDD_OFF_CTRL && PWDATA[`CTIDD_CTRL_START];

  ctidd_ext_value u_value (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .CLEAR(start),
    .TAKE(take && in_value),
    .DATA(SRC_DATA),
    .FINAL(val_final),
    .FIRST(val_first),
    .COUNT(val_count)
  );

  // ****************************************
  // parse sequencing
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CTIDD_IDLE: begin
        if (start) begin
          nxt_state = (PWDATA[`CTIDD_CTRL_SEL_IO]) ? CTIDD_IO : CTIDD_SCALE;
        end
      end
      CTIDD_SCALE: begin
        if (take) begin
          nxt_state = next_field(CTIDD_SCALE, SRC_DATA);
        end
      end
      CTIDD_WAIT, CTIDD_RB, CTIDD_RSV: begin
        if (take && val_final) begin
          nxt_state = next_field(state_ff, scale_ff);
        end
      end
      CTIDD_IO: begin
        if (take && io_idx_ff == `CTIDD_IO_GROUP_LAST && !io_cont_ff) begin
          nxt_state = CTIDD_IDLE;
        end
      end
      default: begin
        nxt_state = CTIDD_IDLE;
      end
    endcase
    // judged before the cut below, or a short source would look complete
    more_due = take && (nxt_state != CTIDD_IDLE);
    if (take && SRC_LAST) begin
      nxt_state = CTIDD_IDLE;
    end
  end

  // source ends while the field still implies more bytes
  assign early_end = take && SRC_LAST && more_due;
  assign finish = (state_ff != CTIDD_IDLE) && (nxt_state == CTIDD_IDLE);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_ff <= CTIDD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // timing field capture
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      scale_ff <= `CTIDD_RST_BYTE;
    end else if (take && state_ff == CTIDD_SCALE) begin
      scale_ff <= SRC_DATA;
    end
  end

  // value registers hold {byte count, first speed byte}
  always_ff @(posedge CLK) begin
    if (SYS_RST || (start && !PWDATA[`CTIDD_CTRL_SEL_IO])) begin
      wait_ff <= 16'h0000;
      rb_ff <= 16'h0000;
      rsv_ff <= 16'h0000;
    end else if (take && val_final) begin
      if (state_ff == CTIDD_WAIT) begin
        wait_ff <= {val_count, val_first};
      end
      if (state_ff == CTIDD_RB) begin
        rb_ff <= {val_count, val_first};
      end
      if (state_ff == CTIDD_RSV) begin
        rsv_ff <= {val_count, val_first};
      end
    end
  end

  // ****************************************
  // i/o-space groups
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST || start) begin
      io_idx_ff <= 2'h0;
      io_cont_ff <= 1'b0;
      io_count_ff <= `CTIDD_RST_BYTE;
      io_last_ff <= 24'h00_0000;
    end else if (take && state_ff == CTIDD_IO) begin
      io_idx_ff <= (io_idx_ff == `CTIDD_IO_GROUP_LAST) ? 2'h0 : io_idx_ff + 2'h1;
      io_last_ff <= {SRC_DATA, io_last_ff[23:8]};
      if (io_idx_ff == 2'h0) begin
        io_cont_ff <= SRC_DATA[`CTIDD_EXT_BIT];
      end
      if (io_idx_ff == `CTIDD_IO_GROUP_LAST) begin
        io_count_ff <= io_count_ff + 8'h01;
      end
    end
  end

  // ****************************************
  // status and interrupts
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST || start) begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      sel_io_ff <= (SYS_RST) ? 1'b0 : PWDATA[`CTIDD_CTRL_SEL_IO];
    end else if (finish) begin
      done_ff <= 1'b1;
      err_ff <= early_end;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      int_stat_ff <= 2'h0;
    end else begin
      int_stat_ff <= (int_stat_ff &
                      ~((wr_en && PADDR == `CTIDD_OFF_INT_CLR) ? PWDATA[1:0] : 2'h0)) |
                     {finish && early_end, finish};
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      int_en_ff <= 2'h0;
    end else if (wr_en && PADDR == `CTIDD_OFF_INT_EN) begin
      int_en_ff <= PWDATA[1:0];
    end
  end

  assign IRQ = |(int_stat_ff & int_en_ff);

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR <= `CTIDD_OFF_INT_CLR);
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // read data is registered in setup so it stands through the access phase
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= `CTIDD_RST_WORD;
    end else if (rd_en) begin
      unique case (PADDR)
        `CTIDD_OFF_CTRL: PRDATA <= {30'h0000_0000, sel_io_ff, 1'b0};
        `CTIDD_OFF_STATUS: PRDATA <= {29'h0000_0000, err_ff, done_ff, SRC_READY};
        `CTIDD_OFF_SCALE: PRDATA <= {24'h00_0000, scale_ff};
        `CTIDD_OFF_WAIT: PRDATA <= {16'h0000, wait_ff};
        `CTIDD_OFF_RDYBSY: PRDATA <= {16'h0000, rb_ff};
        `CTIDD_OFF_RSV: PRDATA <= {16'h0000, rsv_ff};
        `CTIDD_OFF_IOCNT: PRDATA <= {24'h00_0000, io_count_ff};
        `CTIDD_OFF_IOLAST: PRDATA <= {8'h00, io_last_ff};
        `CTIDD_OFF_INT_STAT: PRDATA <= {30'h0000_0000, int_stat_ff};
        `CTIDD_OFF_INT_EN: PRDATA <= {30'h0000_0000, int_en_ff};
        default: PRDATA <= `CTIDD_RST_WORD;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_idle_no_ready: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_ff == CTIDD_IDLE |-> !SRC_READY) else $error("ready raised while idle");

  a_wait_skipped: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && state_ff == CTIDD_SCALE && SRC_DATA[1:0] == 2'h3 |=> state_ff != CTIDD_WAIT)
    else $error("wait value parsed although absent");

  a_rb_skipped: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_ff == CTIDD_RB |-> scale_ff[`CTIDD_RB_HI:`CTIDD_RB_LO] != `CTIDD_RB_ABSENT)
    else $error("busy value parsed although absent");

  a_all_absent: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && state_ff == CTIDD_SCALE && SRC_DATA == 8'hFF |=> state_ff == CTIDD_IDLE && done_ff)
    else $error("timing field did not end after scale byte");

  a_wait_first: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && state_ff == CTIDD_SCALE && SRC_DATA[1:0] != 2'h3 && !SRC_LAST
    |=> state_ff == CTIDD_WAIT) else $error("wait value not parsed first");

  a_order_kept: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_ff == CTIDD_RSV |=> state_ff != CTIDD_WAIT && state_ff != CTIDD_RB)
    else $error("timing values out of order");

  a_ext_continue: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && in_value && SRC_DATA[7] && !SRC_LAST |=> $stable(state_ff))
    else $error("value ended on a byte with bit 7 set");

  a_io_group_end: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && state_ff == CTIDD_IO && io_idx_ff == 2'h2 && !io_cont_ff
    |=> state_ff == CTIDD_IDLE && io_count_ff == $past(io_count_ff) + 8'h01)
    else $error("i/o field did not end after last group");

  a_io_three: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && state_ff == CTIDD_IO && io_idx_ff != 2'h2 |=> $stable(io_count_ff))
    else $error("group counted before its third byte");

  a_early_error: assert property (@(posedge CLK) disable iff (SYS_RST)
    take && SRC_LAST && state_ff == CTIDD_IO && io_idx_ff == 2'h0 |=> err_ff ##1 int_stat_ff[1])
    else $error("early end not flagged");

endmodule : ctidd_decoder

// ==== ctidd_src_model.sv ====
// host reader model: hands descriptor bytes to the decoder one per handshake
`timescale 1ns/10ps

module ctidd_src_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic src_ready,
  output logic src_valid,
  output ctidd_pkg::ctidd_byte_type src_data,
  output logic src_last
);
  import ctidd_pkg::*;
  logic [8:0] q [$];
  logic slow = 1'b0;
  integer seed = 32'h5125_424f;
  logic valid_ff = 1'b0;
  logic last_ff = 1'b0;
  ctidd_byte_type data_ff = 8'hA5;
  assign src_valid = valid_ff;
  assign src_data = data_ff;
  assign src_last = last_ff;

  task push(input logic [7:0] b, input logic last);
    q.push_back({last, b});
  endtask : push

  // ****************************************
  // byte source
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      q.delete();
      valid_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (!(valid_ff && !src_ready)) begin
      if (valid_ff) begin
        void'(q.pop_front());
      end
      if (q.size() > 0 && (!slow || $random(seed) % 2 == 0)) begin
        valid_ff <= 1'b1;
        {last_ff, data_ff} <= q[0];
      end else begin
        valid_ff <= 1'b0;
        last_ff <= 1'b0;
        // released line keeps toggling so no stale byte can be mistaken for data
        data_ff <= ~data_ff;
      end
    end
  end
endmodule : ctidd_src_model

// ==== test_ctidd_decoder.sv ====
// self-checking bench for the descriptor decoder
`timescale 1ns/10ps
`include "ctidd_defines.svh"

module test_ctidd_decoder;
  import ctidd_pkg::*;
  localparam logic [32:0] ERR = 33'h1_0000_0000;
  localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, src_valid, src_last, src_ready, irq;
  ctidd_byte_type src_data;
  logic [65:0] expq [$];
  logic [7:0] bq [$];
  logic [31:0] ev [3];
  logic [7:0] sc;
  logic [7:0] tbl [6] = '{8'hFF, 8'h00, 8'h1F, 8'hE2, 8'hFD, 8'h63};
  integer seed = 32'h5125_424f;
  int err_total = 0;
  int checks_done = 0;

  ctidd_decoder ctidd_decoder_inst (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_VALID(src_valid), .SRC_DATA(src_data),
    .SRC_LAST(src_last), .SRC_READY(src_ready), .IRQ(irq));
  ctidd_src_model ctidd_src_model_inst (.clk(clk), .sys_rst(sys_rst), .src_ready(src_ready),
    .src_valid(src_valid), .src_data(src_data), .src_last(src_last));

  initial begin
    forever #10 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m = ALL);
    expq.push_back({m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // read results are compared as they appear on the bus
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      chk({pslverr, prdata} & expq[0][65:33], expq[0][32:0]);
      void'(expq.pop_front());
    end
  end

  task automatic send(input logic [1:0] ctrl, input int cnt, input int left);
    int n;
    foreach (bq[i]) if (i < cnt) ctidd_src_model_inst.push(bq[i], i == cnt - 1);
    repeat (3) @(posedge clk);
    chk(33'(ctidd_src_model_inst.q.size()), 33'(cnt));
    apb(1'b1, `CTIDD_OFF_CTRL, {30'h0000_0000, ctrl});
    n = 0;
    while (src_ready !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      report_and_stop();
    end
    @(posedge clk);
    chk(33'(ctidd_src_model_inst.q.size()), 33'(left));
  endtask : send

  task automatic build_timing(input logic [7:0] s);
    logic absent;
    int len;
    logic [7:0] b;
    bq = {};
    bq.push_back(s);
    for (int f = 0; f < 3; f++) begin
      absent = f == 0 ? s[1:0] == `CTIDD_WAIT_ABSENT : f == 1 ? s[4:2] == `CTIDD_RB_ABSENT
        : s[7:5] == `CTIDD_RSV_ABSENT;
      ev[f] = 32'h0000_0000;
      len = absent ? 0 : 1 + {$random(seed)} % 3;
      for (int k = 0; k < len; k++) begin
        b = $random(seed);
        b[7] = k != len - 1;
        if (k == 0) ev[f] = {16'h0000, 8'(len), b};
        bq.push_back(b);
      end
    end
  endtask : build_timing

  task automatic build_io(input int groups);
    logic [7:0] b;
    bq = {};
    for (int g = 0; g < groups; g++) begin
      b = $random(seed);
      b[7] = g != groups - 1;
      bq.push_back(b);
      bq.push_back(8'($random(seed)));
      bq.push_back(8'($random(seed)));
    end
    // one byte past the field: must stay with the source
    bq.push_back(8'hFF);
  endtask : build_io

  task automatic reset_check;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(33'(irq), 33'h0);
    chk(33'(src_ready), 33'h0);
    rd(`CTIDD_OFF_STATUS, 33'h0);
    rd(`CTIDD_OFF_IOCNT, 33'h0);
    rd(`CTIDD_OFF_INT_STAT, 33'h0);
    rd(`CTIDD_OFF_INT_EN, 33'h0);
    rd(`CTIDD_OFF_WAIT, 33'h0);
    rd(8'h2C, ERR);
    rd(8'h06, ERR);
  endtask : reset_check

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_check();
    build_io(3);
    send(2'h3, bq.size(), 1);
    rd(`CTIDD_OFF_IOCNT, 33'h3);
    rd(`CTIDD_OFF_IOLAST, {9'h000, bq[8], bq[7], bq[6]});
    rd(`CTIDD_OFF_STATUS, 33'h2, 33'h7);
    rd(`CTIDD_OFF_CTRL, 33'h2);
    reset_check();
    for (int i = 0; i < 10; i++) begin
      sc = i < 6 ? tbl[i] : 8'($random(seed));
      ctidd_src_model_inst.slow <= i[0];
      apb(1'b1, `CTIDD_OFF_INT_EN, i == 0 ? 32'h0000_0000 : 32'h0000_0003);
      build_timing(sc);
      send(2'h1, bq.size(), 0);
      apb(1'b1, `CTIDD_OFF_SCALE, {24'h00_0000, ~sc});
      rd(`CTIDD_OFF_STATUS, 33'h2, 33'h7);
      rd(`CTIDD_OFF_SCALE, {25'h000_0000, sc});
      rd(`CTIDD_OFF_WAIT, {1'b0, ev[0]});
      rd(`CTIDD_OFF_RDYBSY, {1'b0, ev[1]});
      rd(`CTIDD_OFF_RSV, {1'b0, ev[2]});
      rd(`CTIDD_OFF_INT_STAT, 33'h1, 33'h3);
      chk(33'(irq), i == 0 ? 33'h0 : 33'h1);
      apb(1'b1, `CTIDD_OFF_INT_CLR, 32'h0000_0003);
      rd(`CTIDD_OFF_INT_STAT, 33'h0);
      chk(33'(irq), 33'h0);
    end
    apb(1'b1, `CTIDD_OFF_INT_EN, 32'h0000_0002);
    build_timing(8'h00);
    send(2'h1, 1 + {$random(seed)} % (bq.size() - 1), 0);
    rd(`CTIDD_OFF_STATUS, 33'h4, 33'h5);
    rd(`CTIDD_OFF_INT_STAT, 33'h2, 33'h2);
    chk(33'(irq), 33'h1);
    build_io(2);
    send(2'h3, 4, 0);
    rd(`CTIDD_OFF_STATUS, 33'h4, 33'h5);
    report_and_stop();
  end
endmodule : test_ctidd_decoder
